// ==== verilog/grpm_pkg.sv ====
// Constants, types and helpers for the reference, pin and update logic.
package grpm_pkg;

    // ------------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------------
    localparam int NUM_PORTS = 4;
    localparam int NUM_PINS = 8;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int CNT_W_DEF = 24;

    // ------------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_GCTRL = 8'h00;
    localparam logic [7:0] OFS_GSTAT = 8'h04;
    localparam logic [7:0] OFS_PIN_MODE = 8'h08;
    localparam logic [7:0] OFS_ALARM_SEL = 8'h0C;
    localparam logic [7:0] OFS_PIN_DATA = 8'h10;
    localparam logic [7:0] OFS_PORT_CTRL = 8'h14;
    localparam logic [7:0] OFS_PORT_STAT = 8'h18;
    localparam logic [7:0] OFS_COUNT_BASE = 8'h20;

    // ------------------------------------------------------------------
    // Global control and status fields
    // ------------------------------------------------------------------
    localparam int GCTRL_W = 9;
    localparam int GC_REF_IN_SEL = 0;
    localparam int GC_REF_OUT_EN = 1;
    localparam int GC_PM_SRC_LO = 2;
    localparam int GC_UPD_REQ = 4;
    localparam int GC_TRIG = 5;
    localparam int GC_TRIG_PIN = 6;
    localparam int GC_TICK_IE = 7;
    localparam int GC_UPD_IE = 8;
    localparam int GS_TICK_L = 0;
    localparam int GS_UPD_LIVE = 1;
    localparam int GS_UPD_L = 2;
    localparam int GS_TICK_LVL = 3;
    localparam int PS_W = 4;
    localparam int PS_Z2O_L = 2;
    localparam int PS_EVT_L = 3;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [GCTRL_W-1:0] GCTRL_RST = 9'h000;
    localparam logic [15:0] PIN_MODE_RST = 16'h0000;
    localparam logic [31:0] ALARM_SEL_RST = 32'h0000_0000;

    // ------------------------------------------------------------------
    // Timing: reference edges per second and the high half of the tick
    // ------------------------------------------------------------------
    localparam int REF8K_HZ = 8000;
    localparam int TICK_W = 13;
    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(REF8K_HZ - 1);
    localparam logic [TICK_W-1:0] TICK_HIGH = TICK_W'(REF8K_HZ / 2);

    // ------------------------------------------------------------------
    // Codes and pin assignment (pins counted from 0)
    // ------------------------------------------------------------------
    localparam logic [1:0] REF_SEL_RX_FRM = 2'h2;
    localparam logic [1:0] REF_SEL_TX_FRM = 2'h3;
    localparam logic [1:0] PM_SRC_PIN = 2'h1;
    localparam int PM_SRC_TICK_BIT = 1;
    localparam int GP_PIN_REF_OUT = 1;
    localparam int GP_PIN_REF_IN = 3;
    localparam int GP_PIN_TRIG = 5;
    localparam int GP_PIN_UPD = 7;
    localparam logic [3:0] ALM_LAST_SINGLE = 4'hA;
    localparam logic [3:0] ALM_DEFECT = 4'hB;
    localparam logic [3:0] ALM_CELL = 4'hC;
    localparam logic [3:0] ALM_BOTH = 4'hD;
    localparam logic [3:0] ALM_REMOTE = 4'hE;

    typedef enum logic [1:0] {
        PIN_INPUT = 2'h0,
        PIN_ALARM = 2'h1,
        PIN_LOW = 2'h2,
        PIN_HIGH = 2'h3
    } grpm_pin_mode_e;

    typedef enum logic [1:0] {
        UPD_IDLE = 2'h0,
        UPD_CLEAR = 2'h1,
        UPD_HELD = 2'h3
    } grpm_upd_e;

    // Line loss of signal sits in bit 0 so a single-alarm code indexes it.
    typedef struct packed {
        logic lcd;
        logic ocd;
        logic plcp_rai;
        logic plcp_lof;
        logic plcp_oof;
        logic idle;
        logic rai;
        logic ais;
        logic lof;
        logic oof;
        logic los;
    } grpm_alarm_s;

    typedef struct packed {
        logic spare;
        logic own_err;
        logic error_insert_source_sel;
        logic manual_error_trigger;
        logic counter_update_request;
        logic use_global;
        logic [1:0] port_ref_source_sel;
    } grpm_port_ctrl_s;

    localparam grpm_port_ctrl_s PORT_CTRL_RST = '0;

    function automatic logic grpm_alarm_pick(grpm_alarm_s a, logic [3:0] sel);
        logic r;
        r = 1'b0;
        if (sel <= ALM_LAST_SINGLE) begin
            r = a[sel];
        end else if (sel == ALM_DEFECT) begin
            r = a.los | a.lof | a.ais;
        end else if (sel == ALM_CELL) begin
            r = a.plcp_lof | a.lcd;
        end else if (sel == ALM_BOTH) begin
            r = a.los | a.lof | a.ais | a.plcp_lof | a.lcd;
        end else if (sel == ALM_REMOTE) begin
            r = a.rai | a.idle | a.plcp_rai;
        end else begin
            r = |a;
        end
        return r;
    endfunction

endpackage

// ==== verilog/grpm_counter.sv ====
// Saturating event counter with update-clear, read register and status.
`timescale 1ns/100ps
module grpm_counter
    import grpm_pkg::*;
#(
    parameter int CNT_W = CNT_W_DEF
) (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic ce_in,
    input wire logic event_in,
    input wire logic update_in,
    input wire logic clr_z2o_in,
    input wire logic clr_evt_in,
    output logic [CNT_W-1:0] read_out,
    output logic live_out,
    output logic z2o_out,
    output logic evt_out
);
    logic [CNT_W-1:0] count;
    wire at_max = &count;
    wire [CNT_W-1:0] next_count = update_in ? CNT_W'(event_in)
        : (event_in && !at_max) ? count + 1'b1 : count;
    wire set_z2o = event_in && (update_in || count == '0);

    assign live_out = |count;

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            count <= '0;
            read_out <= '0;
            z2o_out <= 1'b0;
            evt_out <= 1'b0;
        end else if (ce_in) begin
            count <= next_count;
            if (update_in) begin
                read_out <= count;
            end
            // A setting event beats a software clear in the same cycle: a zero-to-one event for z2o_out, any event for evt_out.
            z2o_out <= (z2o_out & ~clr_z2o_in) | set_z2o;
            evt_out <= (evt_out & ~clr_evt_in) | event_in;
        end
    end

endmodule // grpm_counter

// ==== verilog/grpm_top.sv ====
// Global reference, second tick, pin mux, counter updates, error routing.
//
// Overview of operation
// - Port reference: PLCP output 0X, receive clock 10, transmit 11.
// - One-second tick divides the global reference by 8000 at half duty.
// - Tick rising edge sets a sticky flag; interrupt only when enabled.
// - With update source 1X, each tick rising edge updates counters.
// - Eight pins, each input, output, global signal or port alarm.
// - Two pins per port show alarms; one of each pair may be global.
// - Disabled-port pins keep working; mode 01 then drives low.
// - Pin-fed trigger and update inputs read low unless selected; unselected ref comes from the source input.
// - Pin 2 reference out, pin 4 reference in, 6 trigger, 8 update.
// - Free pin mode: 00 input, 01 alarm, 10 drive 0, 11 drive 1.
// - Alarm codes 0000 to 1010 each pick a single port alarm.
// - Alarm codes 1011 to 1111 output the OR of alarm groups.
// - Counters hold at least a second of events and saturate.
// - Status: live nonzero bit, zero-to-one latch, per-event latch.
// - Update copies count to read register; clear with event gives one.
// - Update request from tick, pin, per-port bit or global bit.
// - Status follows the request level; its latched copy can interrupt.
// - Ports not using the global request are masked from global status.
// - Update pulses reach every counter-holding block of each port.
// - Error source select 0 uses own bits, 1 the external trigger.
// - External trigger from global bit, port bit or pin 6.
// - In select takes reference from pin 4; out select drives pin 2.
//
// Local design decisions: the register addresses and the plain strobed port.
`timescale 1ns/100ps
module grpm_top
    import grpm_pkg::*;
#(
    parameter int CNT_W = CNT_W_DEF
) (
    input wire logic CLOCK_IN,
    input wire logic RSTN_IN,
    input wire logic CE_IN,
    input wire logic [ADDR_W-1:0] ADDR_IN,
    input wire logic [DATA_W-1:0] WDATA_IN,
    input wire logic WR_IN,
    input wire logic RD_IN,
    output logic [DATA_W-1:0] RDATA_OUT,
    input wire logic [NUM_PINS-1:0] GP_PIN_IN,
    output logic [NUM_PINS-1:0] GP_PIN_OUT,
    output logic [NUM_PINS-1:0] GP_PIN_OE_N_OUT,
    input wire logic [NUM_PORTS-1:0] PORT_EN_IN,
    input wire grpm_alarm_s [NUM_PORTS-1:0] ALARM_IN,
    input wire logic [NUM_PORTS-1:0] PLCP_REF_IN,
    input wire logic [NUM_PORTS-1:0] RX_FRM_CLK_IN,
    input wire logic [NUM_PORTS-1:0] TX_FRM_CLK_IN,
    input wire logic REF8K_SRC_IN,
    input wire logic [NUM_PORTS-1:0] EVENT_IN,
    output logic [NUM_PORTS-1:0] PORT_REF8K_OUT,
    output logic [NUM_PORTS-1:0] UPDATE_OUT,
    output logic [NUM_PORTS-1:0] ERR_INSERT_OUT,
    output logic TICK_IRQ_OUT,
    output logic UPD_IRQ_OUT
);
    localparam int SYNC_W = NUM_PINS + 3 * NUM_PORTS + 1;

    // ------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------
    // Everything here arrives from pins or foreign clocks.
    logic [SYNC_W-1:0] sync_a;
    logic [SYNC_W-1:0] sync_b;
    wire [SYNC_W-1:0] sync_raw = {GP_PIN_IN, PLCP_REF_IN, RX_FRM_CLK_IN,
        TX_FRM_CLK_IN, REF8K_SRC_IN};

    always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            sync_a <= '0;
            sync_b <= '0;
        end else if (CE_IN) begin
            sync_a <= sync_raw;
            sync_b <= sync_a;
        end
    end

    wire ref_src_s = sync_b[0];
    wire [NUM_PORTS-1:0] tx_clk_s = sync_b[NUM_PORTS:1];
    wire [NUM_PORTS-1:0] rx_clk_s = sync_b[2*NUM_PORTS:NUM_PORTS+1];
    wire [NUM_PORTS-1:0] plcp_s = sync_b[3*NUM_PORTS:2*NUM_PORTS+1];
    wire [NUM_PINS-1:0] pin_s = sync_b[SYNC_W-1:3*NUM_PORTS+1];

    // ------------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------------
    logic [GCTRL_W-1:0] gctrl;
    logic [2*NUM_PINS-1:0] pin_mode;
    logic [4*NUM_PINS-1:0] alarm_sel;
    grpm_port_ctrl_s [NUM_PORTS-1:0] port_ctrl;
    logic tick_latched;
    logic upd_latched;

    wire ref8k_in_sel = gctrl[GC_REF_IN_SEL];
    wire ref8k_out_en = gctrl[GC_REF_OUT_EN];
    wire [1:0] pm_update_source_sel = gctrl[GC_PM_SRC_LO+1:GC_PM_SRC_LO];
    wire glob_upd_req = gctrl[GC_UPD_REQ];
    wire glob_trig = gctrl[GC_TRIG];
    wire trig_pin_sel = gctrl[GC_TRIG_PIN];
    wire second_tick_irq_en = gctrl[GC_TICK_IE];
    wire upd_irq_en = gctrl[GC_UPD_IE];

    wire wr_gctrl = WR_IN && ADDR_IN == OFS_GCTRL;
    wire wr_gstat = WR_IN && ADDR_IN == OFS_GSTAT;
    wire wr_pin_mode = WR_IN && ADDR_IN == OFS_PIN_MODE;
    wire wr_alarm_sel = WR_IN && ADDR_IN == OFS_ALARM_SEL;
    wire wr_port_ctrl = WR_IN && ADDR_IN == OFS_PORT_CTRL;
    wire wr_port_stat = WR_IN && ADDR_IN == OFS_PORT_STAT;

    // ------------------------------------------------------------------
    // Global reference and one-second tick
    // ------------------------------------------------------------------
    logic ref_prev;
    logic [TICK_W-1:0] tick_cnt;
    logic tick_level;
    logic tick_prev;

    wire ref8k = ref8k_in_sel ? pin_s[GP_PIN_REF_IN]
        : ref_src_s;
    wire ref_rise = ref8k && !ref_prev;
    wire [TICK_W-1:0] next_tick_cnt = (tick_cnt == TICK_LAST) ? '0
        : tick_cnt + 1'b1;
    wire tick_rise = tick_level && !tick_prev;

    always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            ref_prev <= 1'b0;
            tick_cnt <= '0;
            tick_level <= 1'b0;
            tick_prev <= 1'b0;
        end else if (CE_IN) begin
            ref_prev <= ref8k;
            if (ref_rise) begin
                tick_cnt <= next_tick_cnt;
                tick_level <= next_tick_cnt < TICK_HIGH;
            end
            tick_prev <= tick_level;
        end
    end

    // ------------------------------------------------------------------
    // Counter update sequencing
    // ------------------------------------------------------------------
    // Pin 8 reaches the core only while it is the chosen update source.
    wire pin_upd = (pm_update_source_sel == PM_SRC_PIN)
        && pin_s[GP_PIN_UPD];
    wire glob_req = pm_update_source_sel[PM_SRC_TICK_BIT] ? tick_level
        : (pm_update_source_sel == PM_SRC_PIN) ? pin_upd
        : glob_upd_req;

    grpm_upd_e upd_state [NUM_PORTS];
    logic [NUM_PORTS-1:0] port_req;
    logic [NUM_PORTS-1:0] upd_live;
    logic [NUM_PORTS-1:0] use_global;
    logic [NUM_PORTS-1:0] upd_pulse;
    logic [NUM_PORTS-1:0] ext_trig;
    logic [NUM_PORTS-1:0] port_ref;
    logic upd_glob_prev;

    wire pin_trig = trig_pin_sel && pin_s[GP_PIN_TRIG];
    wire upd_glob = |(upd_live & use_global);

    genvar p;
    generate
        for (p = 0; p < NUM_PORTS; p++) begin : g_port
            grpm_port_ctrl_s pc;
            assign pc = port_ctrl[p];
            assign use_global[p] = pc.use_global;
            assign port_req[p] = pc.use_global ? glob_req
                : pc.counter_update_request;
            assign upd_live[p] = upd_state[p] != UPD_IDLE;
            assign upd_pulse[p] = upd_state[p] == UPD_CLEAR;
            assign ext_trig[p] = glob_trig | pc.manual_error_trigger
                | pin_trig;
            assign port_ref[p] = (pc.port_ref_source_sel == REF_SEL_RX_FRM)
                ? rx_clk_s[p]
                : (pc.port_ref_source_sel == REF_SEL_TX_FRM) ? tx_clk_s[p]
                : plcp_s[p];

            // One clear per request edge however long it is held.
            always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
                if (!RSTN_IN) begin
                    upd_state[p] <= UPD_IDLE;
                end else if (CE_IN) begin
                    unique case (upd_state[p])
                        UPD_IDLE: begin
                            if (port_req[p]) begin
                                upd_state[p] <= UPD_CLEAR;
                            end
                        end
                        UPD_CLEAR: begin
                            upd_state[p] <= port_req[p] ? UPD_HELD
                                : UPD_IDLE;
                        end
                        UPD_HELD: begin
                            if (!port_req[p]) begin
                                upd_state[p] <= UPD_IDLE;
                            end
                        end
                        default: begin
                            upd_state[p] <= UPD_IDLE;
                        end
                    endcase
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // Performance counters
    // ------------------------------------------------------------------
    logic [CNT_W-1:0] cnt_read [NUM_PORTS];
    logic [PS_W*NUM_PORTS-1:0] port_stat;
    logic [NUM_PORTS-1:0] cnt_live;
    logic [NUM_PORTS-1:0] cnt_z2o;
    logic [NUM_PORTS-1:0] cnt_evt;

    generate
        for (p = 0; p < NUM_PORTS; p++) begin : g_cnt
            grpm_counter #(
                .CNT_W(CNT_W)
            ) u_cnt (
                .clk_in(CLOCK_IN),
                .rstn_in(RSTN_IN),
                .ce_in(CE_IN),
                .event_in(EVENT_IN[p]),
                .update_in(upd_pulse[p]),
                .clr_z2o_in(wr_port_stat && WDATA_IN[PS_W*p+PS_Z2O_L]),
                .clr_evt_in(wr_port_stat && WDATA_IN[PS_W*p+PS_EVT_L]),
                .read_out(cnt_read[p]),
                .live_out(cnt_live[p]),
                .z2o_out(cnt_z2o[p]),
                .evt_out(cnt_evt[p])
            );
            assign port_stat[PS_W*p +: PS_W] = {cnt_evt[p], cnt_z2o[p],
                cnt_live[p], upd_live[p]};
        end
    endgenerate

    // ------------------------------------------------------------------
    // General-purpose pins
    // ------------------------------------------------------------------
    logic [NUM_PINS-1:0] next_pin_out;
    logic [NUM_PINS-1:0] next_pin_oe_n;

    genvar i;
    generate
        for (i = 0; i < NUM_PINS; i++) begin : g_pin
            localparam int PORT = i / 2;
            grpm_pin_mode_e mode;
            logic alarm;
            logic claimed;
            assign mode = grpm_pin_mode_e'(pin_mode[2*i +: 2]);
            assign alarm = grpm_alarm_pick(ALARM_IN[PORT],
                alarm_sel[4*i +: 4]);
            assign claimed = (i == GP_PIN_REF_OUT && ref8k_out_en)
                || (i == GP_PIN_REF_IN && ref8k_in_sel)
                || (i == GP_PIN_TRIG && trig_pin_sel)
                || (i == GP_PIN_UPD
                    && pm_update_source_sel == PM_SRC_PIN);
            // Only pin 2 is a global output; the other claims are inputs.
            assign next_pin_oe_n[i] = claimed ? (i != GP_PIN_REF_OUT)
                : (mode == PIN_INPUT);
            assign next_pin_out[i] = claimed ? (i == GP_PIN_REF_OUT && ref8k)
                : (mode == PIN_HIGH)
                || (mode == PIN_ALARM && PORT_EN_IN[PORT]
                    && alarm);
        end
    endgenerate

    // ------------------------------------------------------------------
    // Read multiplexer
    // ------------------------------------------------------------------
    wire [3:0] gstat = {tick_level, upd_latched, upd_glob, tick_latched};
    wire cnt_hit = ADDR_IN[7:4] == OFS_COUNT_BASE[7:4];
    wire [1:0] cnt_idx = ADDR_IN[3:2];
    wire [DATA_W-1:0] rd_mux =
        (ADDR_IN == OFS_GCTRL) ? DATA_W'(gctrl)
        : (ADDR_IN == OFS_GSTAT) ? DATA_W'(gstat)
        : (ADDR_IN == OFS_PIN_MODE) ? DATA_W'(pin_mode)
        : (ADDR_IN == OFS_ALARM_SEL) ? alarm_sel
        : (ADDR_IN == OFS_PIN_DATA) ? DATA_W'(pin_s)
        : (ADDR_IN == OFS_PORT_CTRL) ? DATA_W'(port_ctrl)
        : (ADDR_IN == OFS_PORT_STAT) ? DATA_W'(port_stat)
        : cnt_hit ? DATA_W'(cnt_read[cnt_idx])
        : '0;

    // ------------------------------------------------------------------
    // Register and output flops
    // ------------------------------------------------------------------
    always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            gctrl <= GCTRL_RST;
            pin_mode <= PIN_MODE_RST;
            alarm_sel <= ALARM_SEL_RST;
            port_ctrl <= {NUM_PORTS{PORT_CTRL_RST}};
            tick_latched <= 1'b0;
            upd_latched <= 1'b0;
            upd_glob_prev <= 1'b0;
            RDATA_OUT <= '0;
            GP_PIN_OUT <= '0;
            GP_PIN_OE_N_OUT <= '1;
            PORT_REF8K_OUT <= '0;
            UPDATE_OUT <= '0;
            ERR_INSERT_OUT <= '0;
            TICK_IRQ_OUT <= 1'b0;
            UPD_IRQ_OUT <= 1'b0;
        end else if (CE_IN) begin
            if (wr_gctrl) begin
                gctrl <= WDATA_IN[GCTRL_W-1:0];
            end
            if (wr_pin_mode) begin
                pin_mode <= WDATA_IN[2*NUM_PINS-1:0];
            end
            if (wr_alarm_sel) begin
                alarm_sel <= WDATA_IN;
            end
            if (wr_port_ctrl) begin
                port_ctrl <= WDATA_IN;
            end
            // Writing one clears a sticky flag, but a new edge wins.
            tick_latched <= (tick_latched
                & ~(wr_gstat && WDATA_IN[GS_TICK_L]))
                | tick_rise;
            upd_latched <= (upd_latched & ~(wr_gstat && WDATA_IN[GS_UPD_L]))
                | (upd_glob && !upd_glob_prev);
            upd_glob_prev <= upd_glob;
            RDATA_OUT <= RD_IN ? rd_mux : '0;
            GP_PIN_OUT <= next_pin_out;
            GP_PIN_OE_N_OUT <= next_pin_oe_n;
            PORT_REF8K_OUT <= port_ref;
            UPDATE_OUT <= upd_pulse;
            for (int k = 0; k < NUM_PORTS; k++) begin
                ERR_INSERT_OUT[k] <= port_ctrl[k].error_insert_source_sel
                    ? ext_trig[k] : port_ctrl[k].own_err;
            end
            TICK_IRQ_OUT <= tick_latched && second_tick_irq_en;
            UPD_IRQ_OUT <= upd_latched && upd_irq_en;
        end
    end

endmodule // grpm_top

// ==== dv/grpm_chk.sv ====
// Port assertions for the reference, pin and update block.
`timescale 1ns/100ps
module grpm_chk import grpm_pkg::*; (
    input wire logic CLOCK_IN,
    input wire logic RSTN_IN,
    input wire logic CE_IN,
    input wire logic [ADDR_W-1:0] ADDR_IN,
    input wire logic [DATA_W-1:0] WDATA_IN,
    input wire logic WR_IN,
    input wire logic RD_IN,
    input wire logic [DATA_W-1:0] RDATA_OUT,
    input wire logic [NUM_PINS-1:0] GP_PIN_OUT,
    input wire logic [NUM_PINS-1:0] GP_PIN_OE_N_OUT,
    input wire logic [NUM_PORTS-1:0] UPDATE_OUT,
    input wire logic TICK_IRQ_OUT,
    input wire logic UPD_IRQ_OUT
);
    default clocking dc @(posedge CLOCK_IN);
    endclocking
    default disable iff (!RSTN_IN);
    // Strobes count only with the clock enabled, as the block ignores others.
    wire wr_pm = CE_IN && WR_IN && ADDR_IN == OFS_PIN_MODE;
    wire wr_gc = CE_IN && WR_IN && ADDR_IN == OFS_GCTRL;
    wire rd_gc = CE_IN && RD_IN && ADDR_IN == OFS_GCTRL;
    rdata_idle_a: assert property ($past(CE_IN) && !$past(RD_IN)
        |-> RDATA_OUT == '0) else $error("read data outside read slot");
    unmapped_rd_a: assert property (CE_IN && RD_IN && ADDR_IN == 8'hFC
        |=> RDATA_OUT == '0) else $error("unmapped read not zero");
    gctrl_rb_a: assert property (wr_gc ##2 rd_gc
        |=> RDATA_OUT == 32'($past(WDATA_IN[8:0], 3)))
        else $error("control read back wrong");
    pin_drive_a: assert property (wr_pm && WDATA_IN[1] ##1 CE_IN
        |=> !GP_PIN_OE_N_OUT[0] && GP_PIN_OUT[0] == $past(WDATA_IN[0], 2))
        else $error("driven pin level wrong");
    pin_input_a: assert property (wr_pm && WDATA_IN[1:0] == 2'h0
        ##1 CE_IN |=> GP_PIN_OE_N_OUT[0]) else $error("input pin driven");
    upd_pulse_a: assert property ($past(CE_IN) |->
        (UPDATE_OUT & $past(UPDATE_OUT)) == '0) else $error("long update");
    tick_mask_a: assert property (wr_gc && !WDATA_IN[GC_TICK_IE]
        ##1 CE_IN |=> !TICK_IRQ_OUT) else $error("masked tick irq");
    upd_mask_a: assert property (wr_gc && !WDATA_IN[GC_UPD_IE]
        ##1 CE_IN |=> !UPD_IRQ_OUT) else $error("masked update irq");
endmodule // grpm_chk
bind grpm_top grpm_chk u_chk (.*);

// ==== dv/grpm_board.sv ====
// Board model that resolves each pin from the block and the far driver.
`timescale 1ns/100ps
module grpm_board (
    input wire logic [7:0] out_in,
    input wire logic [7:0] oe_n_in,
    input wire logic [7:0] ext_in,
    output logic [7:0] pin_out
);
    // The block wins where it drives, so a clash never hides its level.
    assign pin_out = (oe_n_in & ext_in) | (~oe_n_in & out_in);
endmodule // grpm_board

// ==== dv/grpm_top_tb.sv ====
// Self-checking bench for the reference, pin and update block.
`timescale 1ns/100ps
module grpm_top_tb import grpm_pkg::*;;
    logic CLOCK_IN = 0, RSTN_IN = 0, CE_IN = 1, WR_IN = 0, RD_IN = 0;
    logic REF8K_SRC_IN = 0, TICK_IRQ_OUT, UPD_IRQ_OUT;
    logic [ADDR_W-1:0] ADDR_IN = '0;
    logic [DATA_W-1:0] WDATA_IN = '0, RDATA_OUT;
    logic [NUM_PINS-1:0] GP_PIN_IN, GP_PIN_OUT, GP_PIN_OE_N_OUT, ext = '1;
    logic [NUM_PORTS-1:0] PORT_EN_IN = '1, PLCP_REF_IN = '1, EVENT_IN = '0;
    logic [NUM_PORTS-1:0] RX_FRM_CLK_IN = '0, TX_FRM_CLK_IN = '1;
    logic [NUM_PORTS-1:0] PORT_REF8K_OUT, UPDATE_OUT, ERR_INSERT_OUT;
    grpm_alarm_s [NUM_PORTS-1:0] ALARM_IN = '0;
    int n_mismatch = 0;
    int checked = 0;
    always #10 CLOCK_IN = ~CLOCK_IN;
    grpm_top u_dut (.*);
    grpm_board u_brd (.out_in(GP_PIN_OUT), .oe_n_in(GP_PIN_OE_N_OUT),
        .ext_in(ext), .pin_out(GP_PIN_IN));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge CLOCK_IN);
        @(negedge CLOCK_IN);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge CLOCK_IN);
        WR_IN <= 1;
        ADDR_IN <= a;
        WDATA_IN <= d;
        @(posedge CLOCK_IN);
        WR_IN <= 0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge CLOCK_IN);
        RD_IN <= 1;
        ADDR_IN <= a;
        @(posedge CLOCK_IN);
        RD_IN <= 0;
        @(negedge CLOCK_IN);
        chk(RDATA_OUT, exp);
    endtask
    task automatic t_pins();
        logic [10:0] grp [5] = '{11'h00D, 11'h480, 11'h48D, 11'h130, 11'h7FF};
        logic [10:0] mk;
        for (int c = 0; c < 4; c++) begin
            wr(OFS_PORT_CTRL, 32'(c));
            settle(4);
            chk(PORT_REF8K_OUT[0], c != 2);
        end
        wr(OFS_PIN_MODE, 32'h1);
        for (int c = 0; c < 16; c++) begin
            mk = (c < 11) ? 11'h001 << c : grp[c - 11];
            wr(OFS_ALARM_SEL, 32'(c));
            ALARM_IN[0] <= mk;
            settle(2);
            chk(GP_PIN_OUT[0], 1);
            @(posedge CLOCK_IN);
            ALARM_IN[0] <= ~mk;
            settle(2);
            chk(GP_PIN_OUT[0], 0);
        end
        @(posedge CLOCK_IN);
        PORT_EN_IN[0] <= 0;
        for (int m = 3; m >= 0; m--) begin
            wr(OFS_PIN_MODE, 32'(m));
            ALARM_IN[0] <= '1;
            settle(2);
            chk({GP_PIN_OE_N_OUT[0], GP_PIN_OUT[0]},
                m ? m == 3 : 2);
        end
        @(posedge CLOCK_IN);
        PORT_EN_IN[0] <= 1;
        ext <= 8'hA5;
        settle(2);
        rd(OFS_PIN_DATA, 32'hA5);
        wr(OFS_GCTRL, 32'h2);
        settle(4);
        chk({GP_PIN_OE_N_OUT[1], GP_PIN_OUT[1]}, 0);
    endtask
    task automatic t_err();
        logic [15:0] t [5] = '{16'h0040, 16'h0020, 16'h2020,
            16'h0030, 16'h4020};
        for (int i = 0; i < 5; i++) begin
            wr(OFS_GCTRL, 32'(t[i][15:8]));
            wr(OFS_PORT_CTRL, 32'(t[i][7:0]));
            settle(4);
            chk(ERR_INSERT_OUT[0], i != 1);
        end
    endtask
    task automatic t_upd();
        int n = 0;
        wr(OFS_GCTRL, '0);
        wr(OFS_PORT_CTRL, '0);
        EVENT_IN[0] <= 1;
        repeat (5) @(posedge CLOCK_IN);
        EVENT_IN[0] <= 0;
        rd(OFS_PORT_STAT, 32'hE);
        wr(OFS_PORT_CTRL, 32'h8);
        repeat (12) begin
            @(negedge CLOCK_IN);
            if (UPDATE_OUT[0] === 1'b1) n++;
        end
        chk(n, 1);
        rd(OFS_COUNT_BASE, 32'h5);
        rd(OFS_PORT_STAT, 32'hD);
        rd(OFS_GSTAT, '0);
        wr(OFS_PORT_CTRL, '0);
        rd(OFS_PORT_STAT, 32'hC);
        wr(OFS_PORT_CTRL, 32'h4);
        wr(OFS_GCTRL, 32'h110);
        rd(OFS_GCTRL, 32'h110);
        settle(3);
        chk(UPD_IRQ_OUT, 1);
        rd(OFS_GSTAT, 32'h6);
        rd(8'hFC, '0);
    endtask
    task automatic t_tick();
        wr(OFS_GCTRL, 32'h8F);
        ext <= 8'hAD;
        settle(6);
        chk(TICK_IRQ_OUT, 1);
        chk(GP_PIN_OUT[1], 1);
        rd(OFS_GSTAT, 32'hF);
        @(posedge CLOCK_IN);
        CE_IN <= 0;
        wr(OFS_GCTRL, '0);
        CE_IN <= 1;
        rd(OFS_GCTRL, 32'h8F);
    endtask
    task automatic conclude();
        if (n_mismatch == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge CLOCK_IN);
        RSTN_IN <= 1;
        t_pins();
        t_err();
        t_upd();
        t_tick();
        conclude();
    end
    // The whole run needs well under a thousand cycles.
    initial begin
        #100000;
        n_mismatch++;
        conclude();
    end
endmodule // grpm_top_tb
